/* File: pdc_bank_div.sv */
// One post-divider bank: source mux and four dividers on edge events.
// Assumes edge events are one-cycle pulses already synchronised to clk_i.
`timescale 1ns/1ps
`default_nettype none
`include "pdc_consts.svh"
module pdc_bank_div (
   input wire logic clk_i,
   input wire logic nrst_i,
   pdc_bank_if.bank bus
);
   // Divisor of one tap; the fourth follows the programmed field
   function automatic pdc_pkg::pdc_divisor_t tap_div(input int idx,
         input pdc_pkg::pdc_divisor_t var_div);
      case (idx)
         0: tap_div = `PDC_FIX_DIV2;
         1: tap_div = `PDC_FIX_DIV3;
         2: tap_div = `PDC_FIX_DIV4;
         default: tap_div = var_div;
      endcase
   endfunction

   // Bank input clock event, oscillator or reference
   wire logic in_evt;
   assign in_evt = bus.source_select ? bus.ref_evt : bus.osc_evt;

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_tap
         pdc_pkg::pdc_divisor_t cnt_reg;
         pdc_pkg::pdc_divisor_t div_reg;
         logic out_reg;
         wire logic wrap;
         wire pdc_pkg::pdc_divisor_t cnt_next;
         // Wrap also covers divisors 0 and 1, which wrap every event and hold the output low
         assign wrap = ({1'b0, cnt_reg} + 8'h01) >= {1'b0, div_reg};
         assign cnt_next = wrap ? 7'h00 : cnt_reg + 7'h01;
         // Count events; new divisor is taken only at wrap
         always_ff @(posedge clk_i or negedge nrst_i) begin
            if (!nrst_i) begin
               cnt_reg <= 7'h00;
               div_reg <= `PDC_FIX_DIV2;
               out_reg <= 1'b0;
            end else if (in_evt) begin
               cnt_reg <= cnt_next;
               if (wrap) begin
                  div_reg <= tap_div(g, bus.bank_variable_divisor);
               end
               out_reg <= cnt_next < (div_reg >> 1);
            end
         end
         assign bus.tap_clk[g] = out_reg;
      end
   endgenerate
endmodule
`default_nettype wire

/* File: pdc_bank_if.sv */
// Interface between the control logic and one post-divider bank.
// Assumes both ends run on the single system clock.
`timescale 1ns/1ps
`default_nettype none
interface pdc_bank_if;
   logic osc_evt;
   logic ref_evt;
   logic source_select;
   pdc_pkg::pdc_divisor_t bank_variable_divisor;
   logic [3:0] tap_clk;
   modport ctrl (
      output osc_evt,
      output ref_evt,
      output source_select,
      output bank_variable_divisor,
      input tap_clk
   );
   modport bank (
      input osc_evt,
      input ref_evt,
      input source_select,
      input bank_variable_divisor,
      output tap_clk
   );
endinterface
`default_nettype wire

/* File: pdc_chk.sv */
// Port assertions for the divider configuration top, bound to it.
// Assumes one clock and outputs that follow a register write two cycles later.
`timescale 1ns/1ps
`default_nettype none
module pdc_chk (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic reg_rvalid_o,
   input wire logic ref_div_tick_o,
   input wire logic [7:0] ref_divide_ratio_o,
   input wire logic [11:0] feedback_ratio_o,
   input wire logic [2:0] charge_setting_o,
   input wire logic [7:0] crystal_load_trim_o,
   input wire logic [3:0] bank1_clk_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   // Write strobes of single registers
   wire logic w13 = reg_wr_i && reg_addr_i == 8'h13;
   wire logic w40 = reg_wr_i && reg_addr_i == 8'h40;
   wire logic w41 = reg_wr_i && reg_addr_i == 8'h41;
   wire logic w42 = reg_wr_i && reg_addr_i == 8'h42;
   property p_rvalid; reg_rd_i |=> reg_rvalid_o; endproperty
   a_rvalid: assert property (p_rvalid) else $error("read answer missing");
   property p_fixed; reg_rd_i && reg_addr_i == 8'h40 |=> reg_rdata_o[7:5] == 3'h6; endproperty
   a_fixed: assert property (p_fixed) else $error("fixed bits wrong");
   property p_ref;
      w42 |-> ##2 ref_divide_ratio_o == {1'b0, $past(reg_wdata_i[6:0], 2)} + 8'h02;
   endproperty
   a_ref: assert property (p_ref) else $error("reference ratio wrong");
   property p_odd; w42 |-> ##2 feedback_ratio_o[0] == $past(reg_wdata_i[7], 2); endproperty
   a_odd: assert property (p_odd) else $error("odd bit wrong");
   property p_fb_low; w41 |-> ##2 feedback_ratio_o[8:1] - 8'h04 == $past(reg_wdata_i, 2);
   endproperty
   a_fb_low: assert property (p_fb_low) else $error("feedback ratio wrong");
   property p_charge; w40 |-> ##2 charge_setting_o == $past(reg_wdata_i[4:2], 2); endproperty
   a_charge: assert property (p_charge) else $error("charge setting wrong");
   property p_trim; w13 |-> ##2 crystal_load_trim_o == $past(reg_wdata_i, 2); endproperty
   a_trim: assert property (p_trim) else $error("load trim wrong");
   property p_hold;
      !reg_wr_i [*2] |=> $stable(charge_setting_o) && $stable(crystal_load_trim_o);
   endproperty
   a_hold: assert property (p_hold) else $error("field moved without write");
   property p_tick; ref_div_tick_o |=> !ref_div_tick_o; endproperty
   a_tick: assert property (p_tick) else $error("tick too long");
   // Main scenarios reached
   c_wr42: cover property (w42);
   c_rd40: cover property (reg_rd_i && reg_addr_i == 8'h40);
   c_bank1: cover property ($rose(bank1_clk_o[3]));
endmodule
bind pdc_top pdc_chk i_pdc_chk (.clk_i, .nrst_i, .reg_wr_i, .reg_rd_i, .reg_addr_i,
   .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o, .ref_div_tick_o, .ref_divide_ratio_o,
   .feedback_ratio_o, .charge_setting_o, .crystal_load_trim_o, .bank1_clk_o);
`default_nettype wire

/* File: pdc_consts.svh */
// Constants for the synthesizer divider configuration block.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef PDC_CONSTS_SVH
`define PDC_CONSTS_SVH

// Register addresses
`define PDC_ADDR_BANK1 8'h0C
`define PDC_ADDR_TRIM 8'h13
`define PDC_ADDR_CHARGE 8'h40
`define PDC_ADDR_FB_LOW 8'h41
`define PDC_ADDR_ODD_REF 8'h42
`define PDC_ADDR_BANK2 8'h47

// Field positions
`define PDC_SRC_BIT 7
`define PDC_DIV_MSB 6
`define PDC_ODD_BIT 7
`define PDC_REF_MSB 6
`define PDC_CHG_MSB 4
`define PDC_CHG_LSB 2
`define PDC_FBH_MSB 1

// Fixed top bits of the charge register
`define PDC_CHARGE_FIXED 3'h6

// Reset values
`define PDC_RST_BANK 8'h08
`define PDC_RST_TRIM 8'h00
`define PDC_RST_CHARGE 5'h00
`define PDC_RST_FB_LOW 8'h00
`define PDC_RST_ODD_REF 8'h00

// Ratio offsets and fixed bank divisors
`define PDC_REF_OFFSET 8'h02
`define PDC_FB_OFFSET 11'h004
`define PDC_FIX_DIV2 7'h02
`define PDC_FIX_DIV3 7'h03
`define PDC_FIX_DIV4 7'h04

`endif

/* File: pdc_host_model.sv */
// Configuration host model: byte writes and reads on the register port.
// Assumes requests are taken on the rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module pdc_host_model (
   input wire logic clk_i,
   input wire logic [7:0] rdata_i,
   input wire logic rvalid_i,
   output logic wr_o,
   output logic rd_o,
   output logic [7:0] addr_o,
   output logic [7:0] wdata_o
);
   // Idle port from time zero
   initial begin
      wr_o = 1'b0;
      rd_o = 1'b0;
      addr_o = 8'h00;
      wdata_o = 8'h00;
   end
   // One byte write, then an idle cycle
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      wr_o <= 1'b1;
      addr_o <= a;
      wdata_o <= d;
      @(posedge clk_i);
      wr_o <= 1'b0;
      @(posedge clk_i);
   endtask
   // One byte read; data and valid taken at the edge where the answer stands
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
      rd_o <= 1'b1;
      addr_o <= a;
      @(posedge clk_i);
      rd_o <= 1'b0;
      @(posedge clk_i);
      v = rvalid_i;
      d = rdata_i;
      @(posedge clk_i);
   endtask
endmodule
`default_nettype wire

/* File: pdc_pkg.sv */
// Types shared by the synthesizer divider configuration modules.
// Assumes pdc_consts.svh is on the include path.
`include "pdc_consts.svh"
package pdc_pkg;
   // Tap order of a divider bank's four outputs
   typedef enum logic [1:0] {
      PDC_TAP_DIV2 = 2'b00,
      PDC_TAP_DIV3 = 2'b01,
      PDC_TAP_DIV4 = 2'b10,
      PDC_TAP_VAR = 2'b11
   } pdc_tap_t;
   typedef logic [6:0] pdc_divisor_t;
   typedef logic [11:0] pdc_fb_ratio_t;
endpackage

/* File: pdc_top.sv */
// Divider configuration top: register file, reference and feedback
// dividers, and the two post-divider banks.
// Assumes register writes come from the serial port logic on clk_i, and
// that reference and oscillator clocks arrive asynchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
`include "pdc_consts.svh"
module pdc_top (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   output logic reg_rvalid_o,
   input wire logic ref_clk_i,
   input wire logic osc_clk_i,
   output logic ref_div_tick_o,
   output logic fb_div_tick_o,
   output logic [7:0] ref_divide_ratio_o,
   output logic [11:0] feedback_ratio_o,
   output logic [2:0] charge_setting_o,
   output logic [7:0] crystal_load_trim_o,
   output logic [3:0] bank1_clk_o,
   output logic [3:0] bank2_clk_o
);
   // Stored register fields
   logic [7:0] bank1_select_divisor_reg;
   logic [7:0] crystal_load_trim_reg;
   logic [4:0] charge_feedback_high_reg;
   logic [7:0] feedback_low_reg;
   logic [7:0] odd_and_ref_divider_reg;
   logic [7:0] bank2_select_divisor_reg;

   // Address decode
   wire logic hit_bank1;
   wire logic hit_trim;
   wire logic hit_charge;
   wire logic hit_fb_low;
   wire logic hit_odd_ref;
   wire logic hit_bank2;
   assign hit_bank1 = reg_addr_i == `PDC_ADDR_BANK1;
   assign hit_trim = reg_addr_i == `PDC_ADDR_TRIM;
   assign hit_charge = reg_addr_i == `PDC_ADDR_CHARGE;
   assign hit_fb_low = reg_addr_i == `PDC_ADDR_FB_LOW;
   assign hit_odd_ref = reg_addr_i == `PDC_ADDR_ODD_REF;
   assign hit_bank2 = reg_addr_i == `PDC_ADDR_BANK2;

   // Bank registers; reserved addresses take no write
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         bank1_select_divisor_reg <= `PDC_RST_BANK;
         bank2_select_divisor_reg <= `PDC_RST_BANK;
      end else if (reg_wr_i) begin
         if (hit_bank1) begin
            bank1_select_divisor_reg <= reg_wdata_i;
         end
         if (hit_bank2) begin
            bank2_select_divisor_reg <= reg_wdata_i;
         end
      end
   end

   // Loop registers; only the writable low five bits of 40H are kept
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         charge_feedback_high_reg <= `PDC_RST_CHARGE;
         feedback_low_reg <= `PDC_RST_FB_LOW;
         odd_and_ref_divider_reg <= `PDC_RST_ODD_REF;
      end else if (reg_wr_i) begin
         if (hit_charge) begin
            charge_feedback_high_reg <= reg_wdata_i[`PDC_CHG_MSB:0];
         end
         if (hit_fb_low) begin
            feedback_low_reg <= reg_wdata_i;
         end
         if (hit_odd_ref) begin
            odd_and_ref_divider_reg <= reg_wdata_i;
         end
      end
   end

   // Crystal load trim register
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         crystal_load_trim_reg <= `PDC_RST_TRIM;
      end else if (reg_wr_i && hit_trim) begin
         crystal_load_trim_reg <= reg_wdata_i;
      end
   end

   // Read mux; unmapped and reserved addresses read zero
   wire logic [7:0] rd_mux;
   assign rd_mux =
      hit_bank1 ? bank1_select_divisor_reg :
      hit_trim ? crystal_load_trim_reg :
      hit_charge ? {`PDC_CHARGE_FIXED, charge_feedback_high_reg} :
      hit_fb_low ? feedback_low_reg :
      hit_odd_ref ? odd_and_ref_divider_reg :
      hit_bank2 ? bank2_select_divisor_reg : 8'h00;

   // Read data is returned one cycle after the request
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         reg_rdata_o <= 8'h00;
         reg_rvalid_o <= 1'b0;
      end else begin
         reg_rvalid_o <= reg_rd_i;
         if (reg_rd_i) begin
            reg_rdata_o <= rd_mux;
         end
      end
   end

   // Field extraction
   wire logic [6:0] ref_field;
   wire logic [9:0] feedback_base_field;
   wire logic feedback_odd_bit;
   wire logic [7:0] ref_ratio;
   wire pdc_pkg::pdc_fb_ratio_t fb_ratio;
   assign ref_field = odd_and_ref_divider_reg[`PDC_REF_MSB:0];
   assign ref_ratio = {1'b0, ref_field} + `PDC_REF_OFFSET;
   assign feedback_base_field = {charge_feedback_high_reg[`PDC_FBH_MSB:0],
      feedback_low_reg};
   assign feedback_odd_bit = odd_and_ref_divider_reg[`PDC_ODD_BIT];
   assign fb_ratio = {({1'b0, feedback_base_field} + `PDC_FB_OFFSET), 1'b0}
      | {11'h000, feedback_odd_bit};

   // Ratios and settings handed to the analog loop
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ref_divide_ratio_o <= 8'h00;
         feedback_ratio_o <= 12'h000;
         charge_setting_o <= 3'h0;
         crystal_load_trim_o <= 8'h00;
      end else begin
         ref_divide_ratio_o <= ref_ratio;
         feedback_ratio_o <= fb_ratio;
         charge_setting_o <= charge_feedback_high_reg[`PDC_CHG_MSB:`PDC_CHG_LSB];
         crystal_load_trim_o <= crystal_load_trim_reg;
      end
   end

   // Two-flop synchronisers plus an edge history stage for each clock pin
   logic [2:0] ref_sync_reg;
   logic [2:0] osc_sync_reg;
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ref_sync_reg <= 3'h0;
         osc_sync_reg <= 3'h0;
      end else begin
         ref_sync_reg <= {ref_sync_reg[1:0], ref_clk_i};
         osc_sync_reg <= {osc_sync_reg[1:0], osc_clk_i};
      end
   end

   // Rising edge events, read only from the second and third stages
   wire logic ref_evt;
   wire logic osc_evt;
   assign ref_evt = ref_sync_reg[1] & ~ref_sync_reg[2];
   assign osc_evt = osc_sync_reg[1] & ~osc_sync_reg[2];

   // Reference divider counts reference edges
   logic [7:0] ref_cnt_reg;
   logic [7:0] ref_div_reg;
   wire logic ref_wrap;
   assign ref_wrap = (ref_cnt_reg + 8'h01) >= ref_div_reg;
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ref_cnt_reg <= 8'h00;
         ref_div_reg <= `PDC_REF_OFFSET;
      end else if (ref_evt) begin
         if (ref_wrap) begin
            ref_cnt_reg <= 8'h00;
            ref_div_reg <= ref_ratio;
         end else begin
            ref_cnt_reg <= ref_cnt_reg + 8'h01;
         end
      end
   end

   // Divided reference tick for the phase comparison
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ref_div_tick_o <= 1'b0;
      end else begin
         ref_div_tick_o <= ref_evt & ref_wrap;
      end
   end

   // Feedback divider counts oscillator edges
   logic [11:0] fb_cnt_reg;
   logic [11:0] fb_div_reg;
   wire logic fb_wrap;
   assign fb_wrap = (fb_cnt_reg + 12'h001) >= fb_div_reg;
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         fb_cnt_reg <= 12'h000;
         fb_div_reg <= {`PDC_FB_OFFSET, 1'b0};
      end else if (osc_evt) begin
         if (fb_wrap) begin
            fb_cnt_reg <= 12'h000;
            fb_div_reg <= fb_ratio;
         end else begin
            fb_cnt_reg <= fb_cnt_reg + 12'h001;
         end
      end
   end

   // Feedback tick; the loop locks when it aligns with the reference tick
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         fb_div_tick_o <= 1'b0;
      end else begin
         fb_div_tick_o <= osc_evt & fb_wrap;
      end
   end

   // Post-divider banks
   pdc_bank_if bank1_if ();
   pdc_bank_if bank2_if ();
   assign bank1_if.osc_evt = osc_evt;
   assign bank1_if.ref_evt = ref_evt;
   assign bank1_if.source_select = bank1_select_divisor_reg[`PDC_SRC_BIT];
   assign bank1_if.bank_variable_divisor =
      bank1_select_divisor_reg[`PDC_DIV_MSB:0];
   assign bank2_if.osc_evt = osc_evt;
   assign bank2_if.ref_evt = ref_evt;
   assign bank2_if.source_select = bank2_select_divisor_reg[`PDC_SRC_BIT];
   assign bank2_if.bank_variable_divisor =
      bank2_select_divisor_reg[`PDC_DIV_MSB:0];

   pdc_bank_div u_bank1 (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .bus(bank1_if.bank)
   );
   pdc_bank_div u_bank2 (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .bus(bank2_if.bank)
   );
   assign bank1_clk_o = bank1_if.tap_clk;
   assign bank2_clk_o = bank2_if.tap_clk;
endmodule
`default_nettype wire

/* File: tb_pll_divider_config.sv */
// Self-checking bench for the divider configuration top.
// Assumes the host model, the bound checker and a 10 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module tb_pll_divider_config;
   logic clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic ref_clk_i = 1'b0;
   logic osc_clk_i = 1'b0;
   logic wr, rd, rvalid, ref_tick, fb_tick;
   logic [7:0] addr, wdata, rdata, ref_ratio, trim;
   logic [11:0] fb_ratio;
   logic [2:0] charge;
   logic [3:0] bank1, bank2;
   logic [9:0] taps;
   int miscompares = 0;
   int tests_run = 0;
   int cycles = 0;
   assign taps = {bank2, bank1, fb_tick, ref_tick};
   pdc_top i_pdc_top (.clk_i, .nrst_i, .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .ref_clk_i, .osc_clk_i,
      .ref_div_tick_o(ref_tick), .fb_div_tick_o(fb_tick), .ref_divide_ratio_o(ref_ratio),
      .feedback_ratio_o(fb_ratio), .charge_setting_o(charge), .crystal_load_trim_o(trim),
      .bank1_clk_o(bank1), .bank2_clk_o(bank2));
   pdc_host_model i_pdc_host_model (.clk_i, .rdata_i(rdata), .rvalid_i(rvalid), .wr_o(wr), .rd_o(rd),
      .addr_o(addr), .wdata_o(wdata));
   initial begin
      forever #50 clk_i = ~clk_i;
   end
   // Oscillator pin: event every 2 cycles; reference pin: every 4; hang guard
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      osc_clk_i <= ~osc_clk_i;
      if (cycles[0]) ref_clk_i <= ~ref_clk_i;
      if (cycles == 20000) begin
         miscompares = miscompares + 1;
         finish_test();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %0t %s: got %0h want %0h", $time, m, seen, exp);
      end
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input string m);
      logic [7:0] d;
      logic v;
      i_pdc_host_model.rd(a, d, v);
      check(v, 1'b1, m);
      check(d, e, m);
   endtask
   task automatic settle();
      repeat (2) @(posedge clk_i);
      #1;
   endtask
   // Cycles between the second and third rising edge of one tap
   task automatic period(input int k, input int exp, input string m);
      int n, c, t;
      logic p;
      n = 0;
      c = 0;
      t = 0;
      p = taps[k];
      while (c < 3 && n < 8000) begin
         @(posedge clk_i);
         #1;
         n++;
         if (taps[k] === 1'b1 && p === 1'b0) begin
            c++;
            if (c == 2) t = n;
         end
         p = taps[k];
      end
      check(n - t, exp, m);
   endtask
   task automatic t_reset();
      check(ref_ratio, 8'h02, "ref ratio");
      check(fb_ratio, 12'h008, "fb ratio");
      rdchk(8'h0C, 8'h08, "0C reset");
      rdchk(8'h13, 8'h00, "13 reset");
      rdchk(8'h40, 8'hC0, "40 reset");
      rdchk(8'h41, 8'h00, "41 reset");
      rdchk(8'h42, 8'h00, "42 reset");
      rdchk(8'h47, 8'h08, "47 reset");
   endtask
   // Extreme ratios, fixed bits, trim and an unmapped place
   task automatic t_regs();
      i_pdc_host_model.wr(8'h42, 8'hFF);
      i_pdc_host_model.wr(8'h41, 8'hFF);
      i_pdc_host_model.wr(8'h40, 8'hE3);
      i_pdc_host_model.wr(8'h13, 8'hA5);
      i_pdc_host_model.wr(8'h43, 8'h5A);
      settle();
      check(ref_ratio, 8'h81, "max ref ratio");
      check(fb_ratio, 12'h807, "max fb ratio");
      check(trim, 8'hA5, "trim out");
      rdchk(8'h40, 8'hC3, "fixed bits");
      rdchk(8'h13, 8'hA5, "trim back");
      rdchk(8'h43, 8'h00, "unmapped");
      i_pdc_host_model.wr(8'h40, 8'h10);
      settle();
      check(charge, 3'h4, "charge");
      rdchk(8'h40, 8'hD0, "fixed kept");
   endtask
   // Loop ratios 7 and 609 with matching charge code 010
   task automatic t_ticks();
      i_pdc_host_model.wr(8'h40, 8'h09);
      i_pdc_host_model.wr(8'h41, 8'h2C);
      i_pdc_host_model.wr(8'h42, 8'h85);
      settle();
      check(ref_ratio, 8'h07, "ref ratio");
      check(fb_ratio, 12'h261, "fb ratio");
      check(charge, 3'h2, "charge");
      period(0, 28, "ref tick");
      period(1, 1218, "fb tick");
   endtask
   // Bank 1 from oscillator /12, bank 2 from reference /8, then bank 1
   // from reference /6 plus its /3 tap, and bank 2 from oscillator /8
   task automatic t_banks();
      int div2 [4] = '{2, 3, 4, 8};
      i_pdc_host_model.wr(8'h0C, 8'h0C);
      i_pdc_host_model.wr(8'h47, 8'h88);
      period(2, 4, "b1 /2");
      period(4, 8, "b1 /4");
      period(5, 24, "b1 var");
      for (int k = 0; k < 4; k++) begin
         period(6 + k, div2[k] * 4, "b2 tap");
      end
      i_pdc_host_model.wr(8'h0C, 8'h86);
      i_pdc_host_model.wr(8'h47, 8'h08);
      period(3, 12, "b1 /3");
      period(5, 24, "b1 ref");
      period(9, 16, "b2 osc");
   endtask
   task automatic finish_test();
      $display("checks %0d miscompares %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge clk_i);
      nrst_i <= 1'b1;
      @(posedge clk_i);
      #1;
      t_reset();
      t_regs();
      t_ticks();
      t_banks();
      finish_test();
   end
endmodule
`default_nettype wire
